// ### rtl/pcfd_pkg.sv
// Package with constants and types for the programmable comparator and fault-dump block.
package pcfd_pkg;

  // Channel count and threshold code width.
  localparam int PCFD_CH = 4;
  localparam int PCFD_CODE_W = 12;

  // Threshold code type and its full-scale value.
  typedef logic [PCFD_CODE_W-1:0] pcfd_code_t;
  localparam pcfd_code_t PCFD_CODE_FULL = 12'hfff;

  // Comparator mode field encodings.
  localparam logic [1:0] PCFD_MODE_PLAIN = 2'h0;
  localparam logic [1:0] PCFD_MODE_HYST = 2'h1;
  localparam logic [1:0] PCFD_MODE_WIN = 2'h2;

  // Pin output source: top bit set routes a window result, low bits pick the channel.
  localparam int PCFD_GPO_WIN_BIT = 3;
  localparam logic [3:0] PCFD_GPO_WIN_CH0 = 4'h8;

  // Pin input function that arms the fault dump on a falling edge.
  localparam logic [3:0] PCFD_GPI_FAULT_FALL = 4'h2;

  // Scratch locations that receive the low and high halves of a read row.
  localparam logic [7:0] PCFD_SCRATCH_LOW_ADDR = 8'h9d;
  localparam logic [7:0] PCFD_SCRATCH_HIGH_ADDR = 8'h9e;

  // Fault-dump row layout: first row holds the status byte on top.
  localparam int PCFD_ROW_W = 32;
  localparam int PCFD_STATUS_POS = 24;
  localparam logic [23:0] PCFD_ROW1_FILL = 24'h000000;

  // Working settings, also the image kept in non-volatile storage.
  typedef struct packed {
    logic [PCFD_CH-1:0][1:0] mode;
    logic [PCFD_CH-1:0] en;
    logic [PCFD_CH-1:0] inv;
    logic [PCFD_CH-1:0] od;
    logic [PCFD_CH-1:0] oe;
    logic [PCFD_CH-1:0][PCFD_CODE_W-1:0] data;
    logic [PCFD_CH-1:0][PCFD_CODE_W-1:0] hi;
    logic [PCFD_CH-1:0][PCFD_CODE_W-1:0] lo;
    logic window_latch_enable;
    logic row_sel;
    logic [3:0] gpo_sel;
    logic pin_input_enable;
    logic pin_output_enable;
    logic [3:0] gpi_sel;
  } pcfd_cfg_s;

  // Settings after reset when nothing has been stored.
  localparam pcfd_cfg_s PCFD_CFG_RST = '0;

endpackage

// ### rtl/pcfd_top.sv
// Digital control of a four-channel threshold comparator with fault dump and settings store.
//
// Overview of operation
// - Each of the four channels runs its own comparator mode.
// - Mode code 00 gives a plain single-threshold comparator.
// - Plain mode takes its threshold from the channel data code.
// - A channel compares only while its enable bit is set.
// - Invert bit set presents the inverted result on the channel output.
// - Open-drain bit picks open-drain or push-pull drive of the output pin.
// - The output pin is driven only while its output-enable bit is 1.
// - Each channel result always shows in a status flag bit.
// - Mode 01 switches at the upper and lower threshold codes.
// - Upper code at full scale or lower at zero makes hysteresis latch.
// - A channel flag-reset pulse releases that channel's latched output.
// - Mode 10 is a window comparator bounded by upper and lower codes.
// - Window results go to status bits, never to channel output pins.
// - One selected channel's window result can drive the general pin.
// - Output source value 1000 routes channel zero's window result.
// - Window-latch bit set makes all window results latching.
// - A latched window result clears only while the input is inside.
// - Fault dump starts on software trigger or mapped pin input event.
// - Input function 0010 starts the fault dump on a pin falling edge.
// - Row read copies low half to scratch 9D and high half to 9E.
// - Row select 0 reads the first stored row, 1 the second.
// - Store trigger saves the current settings in non-volatile storage.
// - Once stored, settings reload from storage on every reset.
// - Threshold codes are 12 bits wide.
`timescale 1ns/1ps
module pcfd_top
  import pcfd_pkg::*;
(
  // Clock, reset, and storage erase.
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic NVM_CLEAR_N,
  // Per-channel comparator settings.
  input wire logic [PCFD_CH-1:0][1:0] CMP_MODE_SEL,
  input wire logic [PCFD_CH-1:0] CMP_ENABLE_BIT,
  input wire logic [PCFD_CH-1:0] CMP_INVERT_BIT,
  input wire logic [PCFD_CH-1:0] OPEN_DRAIN_SEL,
  input wire logic [PCFD_CH-1:0] CMP_PIN_DRIVE_ENABLE,
  input wire logic [PCFD_CH-1:0][PCFD_CODE_W-1:0] DATA_CODE,
  input wire logic [PCFD_CH-1:0][PCFD_CODE_W-1:0] UPPER_THRESHOLD_CODE,
  input wire logic [PCFD_CH-1:0][PCFD_CODE_W-1:0] LOWER_THRESHOLD_CODE,
  // Common settings.
  input wire logic WINDOW_LATCH_ENABLE,
  input wire logic STORED_ROW_SELECT,
  input wire logic [3:0] PIN_OUTPUT_SOURCE_SEL,
  input wire logic PIN_INPUT_ENABLE,
  input wire logic PIN_OUTPUT_ENABLE,
  input wire logic [3:0] PIN_INPUT_FUNCTION_SEL,
  input wire logic CONFIG_WRITE,
  // Trigger inputs.
  input wire logic [PCFD_CH-1:0] LATCH_CLEAR_TRIGGER,
  input wire logic FAULT_DUMP_TRIGGER,
  input wire logic STORE_SETTINGS_TRIGGER,
  input wire logic ROW_READ_TRIGGER,
  // Digitised level at each sense input.
  input wire logic [PCFD_CH-1:0][PCFD_CODE_W-1:0] SENSE_INPUT_PIN,
  // Channel output pins.
  output logic [PCFD_CH-1:0] CMP_OUT,
  output logic [PCFD_CH-1:0] CMP_OE_N,
  // General-purpose pin.
  input wire logic GPIO_IN,
  output logic GPIO_OUT,
  output logic GPIO_OE_N,
  // Status.
  output logic [PCFD_CH-1:0] CMP_RESULT_FLAG,
  output logic [PCFD_CH-1:0] WINDOW_RESULT_BIT,
  output logic [7:0] REG_A,
  output logic NVM_PROGRAMMED,
  // Scratch read port.
  input wire logic [7:0] SCRATCH_ADDR,
  output logic [15:0] SCRATCH_DATA
);

  // Reset synchroniser and working state.
  logic rst_meta;
  logic rst_n;
  pcfd_cfg_s cfg;
  pcfd_cfg_s host_cfg;
  pcfd_cfg_s nvm_cfg;
  logic store_settings_trigger;
  logic load_pending;
  logic [PCFD_ROW_W-1:0] nvm_row0;
  logic [PCFD_ROW_W-1:0] nvm_row1;
  logic [PCFD_ROW_W-1:0] scratch;
  logic [15:0] scratch_out;
  logic [PCFD_CH-1:0] clr_q;
  logic fault_q;
  logic store_q;
  logic read_q;
  logic gpio_q;
  logic [PCFD_CH-1:0] hyst;
  logic [PCFD_CH-1:0] win;
  logic [PCFD_CH-1:0] res;
  logic gpio_val;

  // Reset is asserted at once and released through two flip-flops.
  // Only the second flop feeds the logic, so a release close to a clock edge never spreads.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Host settings gathered into one image.
  // The image reaches the working settings only on a write strobe.
  assign host_cfg.mode = CMP_MODE_SEL;
  assign host_cfg.en = CMP_ENABLE_BIT;
  assign host_cfg.inv = CMP_INVERT_BIT;
  assign host_cfg.od = OPEN_DRAIN_SEL;
  assign host_cfg.oe = CMP_PIN_DRIVE_ENABLE;
  assign host_cfg.data = DATA_CODE;
  assign host_cfg.hi = UPPER_THRESHOLD_CODE;
  assign host_cfg.lo = LOWER_THRESHOLD_CODE;
  assign host_cfg.window_latch_enable = WINDOW_LATCH_ENABLE;
  assign host_cfg.row_sel = STORED_ROW_SELECT;
  assign host_cfg.gpo_sel = PIN_OUTPUT_SOURCE_SEL;
  assign host_cfg.pin_input_enable = PIN_INPUT_ENABLE;
  assign host_cfg.pin_output_enable = PIN_OUTPUT_ENABLE;
  assign host_cfg.gpi_sel = PIN_INPUT_FUNCTION_SEL;

  // Trigger inputs reduced to one-cycle pulses on their rising edge.
  // A trigger held high acts once; it must drop for a cycle before it acts again.
  wire [PCFD_CH-1:0] clr_pulse = LATCH_CLEAR_TRIGGER & ~clr_q;
  wire sw_fault_pulse = FAULT_DUMP_TRIGGER & ~fault_q;
  wire store_pulse = STORE_SETTINGS_TRIGGER & ~store_q;
  wire read_pulse = ROW_READ_TRIGGER & ~read_q;

  // Fault source: software pulse or falling edge on the armed general pin.
  // The pin is watched only once the working settings arm it as a fault input.
  wire gpi_armed = cfg.pin_input_enable && (cfg.gpi_sel == PCFD_GPI_FAULT_FALL);
  wire pin_fall = gpi_armed && gpio_q && !GPIO_IN;
  wire fault_start = sw_fault_pulse || pin_fall;

  // Status byte and the two rows that a fault dump writes.
  // Each data byte keeps the top eight bits of the left-aligned 12-bit code.
  wire [7:0] status_byte = {win, res};
  wire [PCFD_ROW_W-1:0] dump_row0 = {status_byte, PCFD_ROW1_FILL};
  wire [PCFD_ROW_W-1:0] dump_row1 = {cfg.data[0][11:4], cfg.data[1][11:4],
                                     cfg.data[2][11:4], cfg.data[3][11:4]};

  // Edge-detect history of triggers and the general pin.
  // The pin history resets high to match the pulled-up idle level of the net,
  // so the release of reset is never taken for a falling edge.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      clr_q <= 4'h0;
      fault_q <= 1'b0;
      store_q <= 1'b0;
      read_q <= 1'b0;
      gpio_q <= 1'b1;
    end else begin
      clr_q <= LATCH_CLEAR_TRIGGER;
      fault_q <= FAULT_DUMP_TRIGGER;
      store_q <= STORE_SETTINGS_TRIGGER;
      read_q <= ROW_READ_TRIGGER;
      gpio_q <= GPIO_IN;
    end
  end

  // Working settings: restored from storage after reset, then taken on host writes.
  // The restore runs once, in the first cycle after the internal reset lets go.
  // A host write in that same cycle wins, since it carries the newer intent.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= PCFD_CFG_RST;
      load_pending <= 1'b1;
    end else begin
      load_pending <= 1'b0;
      if (CONFIG_WRITE) begin
        cfg <= host_cfg;
      end else if (load_pending && store_settings_trigger) begin
        cfg <= nvm_cfg;
      end
    end
  end

  // Non-volatile model: survives the functional reset, cleared only by erase.
  // Neither a store nor a dump acts while the internal reset is still held.
  // A new dump overwrites both rows, so only the latest fault is kept.
  always_ff @(posedge CLK or negedge NVM_CLEAR_N) begin
    if (!NVM_CLEAR_N) begin
      nvm_cfg <= PCFD_CFG_RST;
      store_settings_trigger <= 1'b0;
      nvm_row0 <= 32'h00000000;
      nvm_row1 <= 32'h00000000;
    end else begin
      if (store_pulse && rst_n) begin
        nvm_cfg <= cfg;
        store_settings_trigger <= 1'b1;
      end
      if (fault_start && rst_n) begin
        nvm_row0 <= dump_row0;
        nvm_row1 <= dump_row1;
      end
    end
  end

  // Row read into scratch and registered scratch read-back.
  // Read data follows the address by one cycle; unused addresses read zero.
  // A row read lands one cycle after its trigger, so fresh data lags by two.
  assign scratch_out = (SCRATCH_ADDR == PCFD_SCRATCH_LOW_ADDR) ? scratch[15:0] :
                       (SCRATCH_ADDR == PCFD_SCRATCH_HIGH_ADDR) ? scratch[31:16] :
                       16'h0000;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      scratch <= 32'h00000000;
      SCRATCH_DATA <= 16'h0000;
    end else begin
      if (read_pulse) begin
        scratch <= cfg.row_sel ? nvm_row1 : nvm_row0;
      end
      SCRATCH_DATA <= scratch_out;
    end
  end

  // Per-channel comparators, each with its own mode.
  // Each compares the digitised sense level against its codes; in plain mode the
  // result is high while the level lies below the data code.
  for (genvar ch = 0; ch < PCFD_CH; ch++) begin : g_ch
    wire [PCFD_CODE_W-1:0] sense = SENSE_INPUT_PIN[ch];
    wire above_hi = sense > cfg.hi[ch];
    wire below_lo = sense < cfg.lo[ch];
    wire below_data = sense < cfg.data[ch];
    wire outside = above_hi || below_lo;
    // Resting level of the hysteresis state: low when the upper code is full scale.
    wire idle = (cfg.hi[ch] != PCFD_CODE_FULL);
    wire raw = (cfg.mode[ch] == PCFD_MODE_PLAIN) ? below_data :
               (cfg.mode[ch] == PCFD_MODE_HYST) ? hyst[ch] : 1'b0;
    wire next_res = raw ^ cfg.inv[ch];

    // Hysteresis state: an upper crossing pulls it low, a lower crossing pulls it high.
    // With a threshold code at its limit one crossing never comes, so the state sticks
    // until a flag-reset pulse returns it to its resting level.
    always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
        hyst[ch] <= 1'b1;
      end else if (!cfg.en[ch]) begin
        hyst[ch] <= idle;
      end else if (clr_pulse[ch]) begin
        hyst[ch] <= idle;
      end else if (above_hi) begin
        hyst[ch] <= 1'b0;
      end else if (below_lo) begin
        hyst[ch] <= 1'b1;
      end
    end

    // Window state: transparent, or latched until a flag-reset comes with the input inside.
    // An outside level in the same cycle as the reset keeps the latch set.
    always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
        win[ch] <= 1'b0;
      end else if (!cfg.en[ch] || (cfg.mode[ch] != PCFD_MODE_WIN)) begin
        win[ch] <= 1'b0;
      end else if (!cfg.window_latch_enable || outside) begin
        win[ch] <= outside;
      end else if (clr_pulse[ch]) begin
        win[ch] <= 1'b0;
      end
    end

    // Registered channel result; a disabled channel reads zero.
    always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
        res[ch] <= 1'b0;
      end else if (!cfg.en[ch]) begin
        res[ch] <= 1'b0;
      end else begin
        res[ch] <= next_res;
      end
    end

    // Pin drive: open-drain only pulls low, push-pull drives both levels.
    // In open-drain mode a high result releases the pin and the pull-up sets the level.
    assign CMP_OUT[ch] = res[ch] && !cfg.od[ch];
    assign CMP_OE_N[ch] = !(cfg.oe[ch] && (!cfg.od[ch] || !res[ch]));
  end

  // General pin output: window result of the selected channel.
  // A source value without its top bit set keeps the pin low.
  assign gpio_val = cfg.gpo_sel[PCFD_GPO_WIN_BIT] && win[cfg.gpo_sel[1:0]];
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      GPIO_OUT <= 1'b0;
    end else begin
      GPIO_OUT <= gpio_val;
    end
  end
  assign GPIO_OE_N = !cfg.pin_output_enable;

  // Status outputs.
  // The status byte holds the window bits above the result flags.
  assign CMP_RESULT_FLAG = res;
  assign WINDOW_RESULT_BIT = win;
  assign REG_A = status_byte;
  assign NVM_PROGRAMMED = store_settings_trigger;

endmodule

// ### dv/pcfd_board_model.sv
// Board model: the net joining channel zero's output pin to the general pin.
`timescale 1ns/1ps
module pcfd_board_model (
  // Channel zero pin.
  input wire logic cmp_out,
  input wire logic cmp_oe_n,
  // General pin.
  input wire logic gpio_out,
  input wire logic gpio_oe_n,
  output logic gpio_in
);
  // The net has a pull-up, so it rests high while neither side drives it.
  assign gpio_in = !gpio_oe_n ? gpio_out : (!cmp_oe_n ? cmp_out : 1'b1);
endmodule

// ### dv/pcfd_top_sva.sv
// Port assertions for the comparator and fault-dump block.
`timescale 1ns/1ps
module pcfd_top_chk
  import pcfd_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // Settings, triggers and scratch address.
  input wire logic [PCFD_CH-1:0] OPEN_DRAIN_SEL,
  input wire logic [PCFD_CH-1:0] CMP_PIN_DRIVE_ENABLE,
  input wire logic [3:0] PIN_OUTPUT_SOURCE_SEL,
  input wire logic PIN_OUTPUT_ENABLE,
  input wire logic CONFIG_WRITE,
  input wire logic STORE_SETTINGS_TRIGGER,
  input wire logic [7:0] SCRATCH_ADDR,
  // Outputs.
  input wire logic [PCFD_CH-1:0] CMP_OUT,
  input wire logic [PCFD_CH-1:0] CMP_OE_N,
  input wire logic GPIO_OUT,
  input wire logic GPIO_OE_N,
  input wire logic [PCFD_CH-1:0] CMP_RESULT_FLAG,
  input wire logic [PCFD_CH-1:0] WINDOW_RESULT_BIT,
  input wire logic [7:0] REG_A,
  input wire logic NVM_PROGRAMMED,
  input wire logic [15:0] SCRATCH_DATA
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // A write with no window source, followed by two quiet cycles.
  sequence no_src_write;
    CONFIG_WRITE && !PIN_OUTPUT_SOURCE_SEL[PCFD_GPO_WIN_BIT] ##1 !CONFIG_WRITE [*2];
  endsequence
  status_map_a: assert property (REG_A == {WINDOW_RESULT_BIT, CMP_RESULT_FLAG})
    else $error("status byte differs from its bits");
  pin_flag_a: assert property ((CMP_OUT & ~CMP_RESULT_FLAG) == '0)
    else $error("pin high while flag low");
  od_data_a: assert property (CONFIG_WRITE |=> (CMP_OUT & $past(OPEN_DRAIN_SEL)) == '0)
    else $error("open-drain pin drives high");
  oe_off_a: assert property (CONFIG_WRITE |=> (~CMP_OE_N & ~$past(CMP_PIN_DRIVE_ENABLE)) == '0)
    else $error("pin enabled without its enable bit");
  gpio_oe_a: assert property (CONFIG_WRITE |=> GPIO_OE_N == !$past(PIN_OUTPUT_ENABLE))
    else $error("general pin enable wrong");
  gpo_off_a: assert property (no_src_write |-> !GPIO_OUT)
    else $error("general pin high with no source");
  scratch_zero_a: assert property (!(SCRATCH_ADDR inside {8'h9d, 8'h9e}) |=> SCRATCH_DATA == '0)
    else $error("scratch data at unused address");
  store_settings_trigger_a: assert property ($rose(STORE_SETTINGS_TRIGGER) |=> NVM_PROGRAMMED)
    else $error("store did not mark storage");
endmodule
bind pcfd_top pcfd_top_chk pcfd_top_chk_i (.CLK(CLK), .RST_N(RST_N),
  .OPEN_DRAIN_SEL(OPEN_DRAIN_SEL), .CMP_PIN_DRIVE_ENABLE(CMP_PIN_DRIVE_ENABLE),
  .PIN_OUTPUT_SOURCE_SEL(PIN_OUTPUT_SOURCE_SEL), .PIN_OUTPUT_ENABLE(PIN_OUTPUT_ENABLE),
  .CONFIG_WRITE(CONFIG_WRITE), .STORE_SETTINGS_TRIGGER(STORE_SETTINGS_TRIGGER),
  .SCRATCH_ADDR(SCRATCH_ADDR), .CMP_OUT(CMP_OUT), .CMP_OE_N(CMP_OE_N), .GPIO_OUT(GPIO_OUT),
  .GPIO_OE_N(GPIO_OE_N), .CMP_RESULT_FLAG(CMP_RESULT_FLAG),
  .WINDOW_RESULT_BIT(WINDOW_RESULT_BIT), .REG_A(REG_A), .NVM_PROGRAMMED(NVM_PROGRAMMED),
  .SCRATCH_DATA(SCRATCH_DATA));

// ### dv/pcfd_top_tb_top.sv
// Self-checking bench for the comparator and fault-dump block.
`timescale 1ns/1ps
module pcfd_top_tb_top
  import pcfd_pkg::*;
;
  logic CLK = 0, RST_N = 0, NVM_CLEAR_N = 0, CONFIG_WRITE = 0;
  logic [3:0][1:0] mode = '0;
  logic [3:0] en = '0, inv = '0, od = '0, oe = '0, gpo_sel = '0, gpi_sel = '0;
  logic [3:0][11:0] data = '0, hi = '0, lo = '0, sense = '0;
  logic wlatch = 0, rsel = 0, pin_input_enable = 0, pin_output_enable = 0, gpio_in, gpio_out, gpio_oe_n, store_settings_trigger;
  logic [6:0] trg = '0;
  logic [7:0] saddr = '0, reg_a;
  logic [3:0] cmp_out, cmp_oe_n, flag, win;
  logic [15:0] sdata;
  int mismatches = 0, n_compared = 0, cycles = 0;
  // Design under test, with trigger bits {row read, store, fault, clear[3:0]}.
  pcfd_top pcfd_top_i (.CLK(CLK), .RST_N(RST_N), .NVM_CLEAR_N(NVM_CLEAR_N),
    .CMP_MODE_SEL(mode), .CMP_ENABLE_BIT(en), .CMP_INVERT_BIT(inv), .OPEN_DRAIN_SEL(od),
    .CMP_PIN_DRIVE_ENABLE(oe), .DATA_CODE(data), .UPPER_THRESHOLD_CODE(hi),
    .LOWER_THRESHOLD_CODE(lo), .WINDOW_LATCH_ENABLE(wlatch), .STORED_ROW_SELECT(rsel),
    .PIN_OUTPUT_SOURCE_SEL(gpo_sel), .PIN_INPUT_ENABLE(pin_input_enable), .PIN_OUTPUT_ENABLE(pin_output_enable),
    .PIN_INPUT_FUNCTION_SEL(gpi_sel), .CONFIG_WRITE(CONFIG_WRITE),
    .LATCH_CLEAR_TRIGGER(trg[3:0]), .FAULT_DUMP_TRIGGER(trg[4]),
    .STORE_SETTINGS_TRIGGER(trg[5]), .ROW_READ_TRIGGER(trg[6]), .SENSE_INPUT_PIN(sense),
    .CMP_OUT(cmp_out), .CMP_OE_N(cmp_oe_n), .GPIO_IN(gpio_in), .GPIO_OUT(gpio_out),
    .GPIO_OE_N(gpio_oe_n), .CMP_RESULT_FLAG(flag), .WINDOW_RESULT_BIT(win), .REG_A(reg_a),
    .NVM_PROGRAMMED(store_settings_trigger), .SCRATCH_ADDR(saddr), .SCRATCH_DATA(sdata));
  pcfd_board_model pcfd_board_model_i (.cmp_out(cmp_out[0]), .cmp_oe_n(cmp_oe_n[0]),
    .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .gpio_in(gpio_in));
  // Clock of 25 ns and a cycle ceiling that cuts a hang short.
  always #12.5 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end
  // Helpers: wait and settle, write settings, pulse triggers, compare.
  task tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task wr();
    @(posedge CLK) CONFIG_WRITE <= 1'b1;
    @(posedge CLK) CONFIG_WRITE <= 1'b0;
  endtask
  task pulse(input logic [6:0] m);
    @(posedge CLK) trg <= m;
    @(posedge CLK) trg <= '0;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task sf(input logic [11:0] v, input logic e);
    @(posedge CLK) sense[0] <= v;
    tick(3);
    chk(16'(flag[0]), 16'(e));
  endtask
  task sw(input logic [11:0] v, input logic e);
    @(posedge CLK) sense[0] <= v;
    tick(3);
    chk(16'({win[0], gpio_out, flag[0]}), 16'({e, e, 1'b0}));
  endtask
  task rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge CLK) saddr <= a;
    pulse(7'h40);
    tick(3);
    chk(sdata, exp);
  endtask
  task end_of_test();
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (8) @(posedge CLK);
    NVM_CLEAR_N <= 1'b1;
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    tick(4);
    @(posedge CLK) en <= 4'hf;
    data <= {4{12'd1024}};
    sense <= {12'd1100, 12'd1000, 12'd1100, 12'd1000};
    wr();
    tick(3);
    chk(16'(flag), 16'h5);
    @(posedge CLK) en <= 4'hb;
    inv <= 4'h2;
    oe <= 4'h1;
    wr();
    tick(3);
    chk(16'(flag), 16'h3);
    chk(16'({cmp_oe_n, cmp_out}), 16'he3);
    @(posedge CLK) od <= 4'h1;
    wr();
    tick(3);
    chk(16'({cmp_oe_n, cmp_out}), 16'hf2);
    @(posedge CLK) mode <= {2'h3, PCFD_MODE_WIN, PCFD_MODE_HYST, PCFD_MODE_PLAIN};
    {en, inv, od, oe} <= 16'hf000;
    wr();
    tick(3);
    chk(16'(reg_a), 16'h41);
    @(posedge CLK) mode[0] <= PCFD_MODE_HYST;
    hi[0] <= 12'd3072;
    lo[0] <= 12'd1024;
    wr();
    sf(12'd3500, 1'b0);
    sf(12'd2000, 1'b0);
    sf(12'd500, 1'b1);
    sf(12'd2000, 1'b1);
    @(posedge CLK) hi[0] <= 12'hfff;
    wr();
    pulse(7'h01);
    sf(12'd2000, 1'b0);
    sf(12'd500, 1'b1);
    sf(12'd2000, 1'b1);
    pulse(7'h01);
    sf(12'd2000, 1'b0);
    @(posedge CLK) hi[0] <= 12'd3072;
    lo[0] <= 12'd0;
    wr();
    pulse(7'h01);
    sf(12'd2000, 1'b1);
    sf(12'd3500, 1'b0);
    sf(12'd0, 1'b0);
    pulse(7'h01);
    sf(12'd0, 1'b1);
    @(posedge CLK) mode[0] <= PCFD_MODE_WIN;
    lo[0] <= 12'd1024;
    gpo_sel <= PCFD_GPO_WIN_CH0;
    pin_output_enable <= 1'b1;
    wr();
    tick(1);
    chk(16'(gpio_oe_n), 16'h0);
    sw(12'd3500, 1'b1);
    sw(12'd2000, 1'b0);
    sw(12'd500, 1'b1);
    sw(12'd2000, 1'b0);
    @(posedge CLK) wlatch <= 1'b1;
    wr();
    sw(12'd3500, 1'b1);
    sw(12'd2000, 1'b1);
    @(posedge CLK) sense[0] <= 12'd500;
    pulse(7'h01);
    sw(12'd500, 1'b1);
    @(posedge CLK) sense[0] <= 12'd2000;
    pulse(7'h01);
    sw(12'd2000, 1'b0);
    @(posedge CLK) mode <= '0;
    en <= 4'h9;
    inv <= 4'h8;
    oe <= 4'h1;
    {gpo_sel, wlatch, pin_output_enable} <= 6'h00;
    pin_input_enable <= 1'b1;
    gpi_sel <= PCFD_GPI_FAULT_FALL;
    data <= {12'h000, 12'h456, 12'h123, 12'd2048};
    wr();
    sf(12'd1000, 1'b1);
    sf(12'd3000, 1'b0);
    rd(8'h9d, 16'h0000);
    rd(8'h9e, 16'h0800);
    @(posedge CLK) rsel <= 1'b1;
    wr();
    rd(8'h9d, 16'h4500);
    rd(8'h9e, 16'h8012);
    @(posedge CLK) data[1] <= 12'h9a0;
    wr();
    pulse(7'h10);
    rd(8'h9e, 16'h809a);
    pulse(7'h20);
    tick(1);
    chk(16'(store_settings_trigger), 16'h1);
    @(posedge CLK) inv[0] <= 1'b1;
    wr();
    tick(3);
    chk(16'(flag), 16'h9);
    @(posedge CLK) RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    tick(6);
    chk(16'(flag), 16'h8);
    end_of_test();
  end
endmodule
